// file: core/sba_arbiter.sv
// High-speed system bus arbiter with timeout error logging
// Operation
// (RL1) Control bit 0: 0 fixed priority, 1 fair rotation among requesters.
// (RL2) Bits 1:3 pick ranking 0125, 1250, 2501, 5012; codes 4-7 reserved.
// (RL3) Control bit 4 enables high utilization; bits 5-31 read zero.
// (RL4) Error address register captures the full 32-bit timed-out address.
// (RL5) Timeout flags for masters 0, 1, 2 at status bits 0, 4, 8.
// (RL6) Direction bits 1, 5, 9 record failing op: 0 write, 1 read.
// (RL7) Field lock bits 2, 6, 10 read 1 while that slot is locked.
// (RL8) Address lock bits 3, 7, 11 show who owns the captured address.
// (RL9) Slots: 0 instruction fetch, 1 data access, 2 external master.
// (RL10) Locked fields and address are not overwritten until software clears.
// (RL11) Software clears serviced status so later timeouts are captured.
module sba_arbiter
  import sba_pkg::*;
#(
  parameter int TIMEOUT_CYC = SBA_TIMEOUT_CYC
)
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  // Masters 0,1,2,5 on indices 0..3
  input  wire sba_mreq_s [3:0]       mreq_i,
  output logic           [3:0]       gnt_o,
  output logic           [3:0]       tmo_o,
  // Device control register port
  input  wire logic [SBA_DCR_AW-1:0] dcr_addr_i,
  input  wire logic                  dcr_read_i,
  input  wire logic                  dcr_write_i,
  input  wire logic [31:0]           dcr_wdata_i,
  output logic      [31:0]           dcr_rdata_o,
  output logic                       dcr_ack_o
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] TMO_LAST = CW'(TIMEOUT_CYC - 1);

  initial begin
    if (TIMEOUT_CYC < 2) $error("TIMEOUT_CYC must be at least 2");
  end

  typedef enum logic [1:0] {IDLE, GAP, OWNED} sba_state_e;

  sba_state_e      st_q;
  sba_ctrl_s       ctrl_q;
  logic [1:0]      own_q, last_q;
  logic [CW-1:0]   cnt_q;
  logic [31:0]     ear_q;
  logic [31:0]     rdata_q;
  logic            ack_q;
  logic [11:0]     status;

  // Register decode
  wire sel_st   = dcr_addr_i == SBA_OFF_STATUS;
  wire sel_ad   = dcr_addr_i == SBA_OFF_ADDR;
  wire sel_ct   = dcr_addr_i == SBA_OFF_CTRL;
  wire wr_ct    = dcr_write_i & sel_ct;
  wire wr_st    = dcr_write_i & sel_st;

  // Arbitration base: reserved codes fall back to the first ranking
  wire [1:0] fix_base = (ctrl_q.order <= SBA_ORD_LAST) ?
                        ctrl_q.order[1:0] : 2'h0; // RL2
  wire [1:0] base     = ctrl_q.fair ? 2'(last_q + 2'h1) : fix_base; // RL1

  logic       win_v;
  logic [1:0] win;
  always_comb begin
    logic [1:0] cand;
    cand  = 2'h0;
    win_v = 1'b0;
    win   = 2'h0;
    for (int p = SBA_MASTERS - 1; p >= 0; p--) begin
      cand = 2'(base + 2'(p));
      if (mreq_i[cand].req) begin
        win_v = 1'b1;
        win   = cand;
      end
    end
  end

  wire owner_req = mreq_i[own_q].req;
  wire timeout   = (st_q == OWNED) && owner_req && (cnt_q == TMO_LAST);
  wire release_b = (st_q == OWNED) && (!owner_req || timeout);
  wire can_grant = (st_q == IDLE) || (st_q == GAP && ctrl_q.high_utilization_enable);

  // Arbitration and tenure timing
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q   <= IDLE;
      own_q  <= 2'h0;
      last_q <= 2'h3;
      cnt_q  <= '0;
    end else begin
      case (st_q)
        IDLE: begin
          if (win_v) begin
            st_q   <= OWNED;
            own_q  <= win;
            last_q <= win;
            cnt_q  <= '0;
          end
        end
        GAP: begin
          // High utilization lets the next master in without the idle cycle
          if (ctrl_q.high_utilization_enable && win_v) begin // RL3
            st_q   <= OWNED;
            own_q  <= win;
            last_q <= win;
            cnt_q  <= '0;
          end else begin
            st_q <= IDLE;
          end
        end
        OWNED: begin
          if (release_b) st_q <= GAP;
          else cnt_q <= CW'(cnt_q + 1'b1);
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  always_comb begin
    gnt_o = 4'h0;
    tmo_o = 4'h0;
    if (st_q == OWNED) begin
      gnt_o[own_q] = 1'b1;
      tmo_o[own_q] = timeout;
    end
  end

  // Timeout logging for masters 0..2; DMA timeouts are not logged
  wire any_alk   = status[SBA_ST_ALK] |
                   status[SBA_ST_STRIDE + SBA_ST_ALK] |
                   status[2*SBA_ST_STRIDE + SBA_ST_ALK];
  wire addr_take = ~any_alk; // RL10

  for (genvar m = 0; m < SBA_LOGGED; m++) begin : g_slot
    sba_err_slot u_slot (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .tmo_i       (tmo_o[m]), // RL9
      .rnw_i       (mreq_i[m].rnw),
      .addr_take_i (addr_take),
      .clr_i       (wr_st ? dcr_wdata_i[m*SBA_ST_STRIDE +: 4] : 4'h0), // RL11
      .slot_o      (status[m*SBA_ST_STRIDE +: 4])
    );
  end

  wire log_tmo = |tmo_o[SBA_LOGGED-1:0];

  // Control and error address registers
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= sba_ctrl_s'(SBA_CTL_RESET);
      ear_q  <= 32'h0000_0000;
    end else begin
      if (wr_ct) begin
        ctrl_q.fair  <= dcr_wdata_i[SBA_CTL_MODE]; // RL1
        ctrl_q.order <= dcr_wdata_i[SBA_CTL_ORD_LO +: 3]; // RL2
        ctrl_q.high_utilization_enable   <= dcr_wdata_i[SBA_CTL_HBU]; // RL3
      end
      if (log_tmo && addr_take) ear_q <= mreq_i[own_q].addr; // RL4
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  wire [31:0] rd_mux = sel_st ? {20'h0_0000, status} :
                       sel_ad ? ear_q :
                       sel_ct ? {27'h000_0000, ctrl_q} : 32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= dcr_read_i | dcr_write_i;
      if (dcr_read_i) rdata_q <= rd_mux;
    end
  end

  assign dcr_rdata_o = rdata_q;
  assign dcr_ack_o   = ack_q;
endmodule

// file: core/sba_pkg.sv
// Shared constants and types for the system bus arbiter and its timeout log
package sba_pkg;
  localparam int          SBA_MASTERS     = 4;
  localparam int          SBA_LOGGED      = 3;
  localparam int          SBA_AW          = 32;
  localparam int          SBA_DCR_AW      = 10;
  // Register offsets on the device control register port
  localparam logic [9:0]  SBA_OFF_STATUS  = 10'h084;
  localparam logic [9:0]  SBA_OFF_ADDR    = 10'h086;
  localparam logic [9:0]  SBA_OFF_CTRL    = 10'h087;
  // Control register fields and reset value
  localparam int          SBA_CTL_MODE    = 0;
  localparam int          SBA_CTL_ORD_LO  = 1;
  localparam int          SBA_CTL_HBU     = 4;
  localparam logic [4:0]  SBA_CTL_RESET   = 5'h00;
  localparam logic [2:0]  SBA_ORD_LAST    = 3'h3;
  // Status nibble layout per logged master
  localparam int          SBA_ST_FLAG     = 0;
  localparam int          SBA_ST_DIR      = 1;
  localparam int          SBA_ST_FLK      = 2;
  localparam int          SBA_ST_ALK      = 3;
  localparam int          SBA_ST_STRIDE   = 4;
  // Timeout figure in bus cycles
  localparam int          SBA_TIMEOUT_CYC = 16;

  typedef struct packed {
    logic              req;
    logic              rnw;
    logic [SBA_AW-1:0] addr;
  } sba_mreq_s;

  typedef struct packed {
    logic       high_utilization_enable;
    logic [2:0] order;
    logic       fair;
  } sba_ctrl_s;
endpackage

// file: core/sba_err_slot.sv
// Per-master timeout status slot: flag, direction, field and address locks
module sba_err_slot
  import sba_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Event from the arbiter
  input  wire logic       tmo_i,
  input  wire logic       rnw_i,
  input  wire logic       addr_take_i,
  // Software write-one-to-clear
  input  wire logic [3:0] clr_i,
  // Slot contents
  output logic      [3:0] slot_o
);
  logic flag_q, dir_q, flk_q, alk_q;
  wire  upd = tmo_i & ~flk_q; // RL10

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
      dir_q  <= 1'b0;
      flk_q  <= 1'b0;
      alk_q  <= 1'b0;
    end else begin
      // Hardware set wins over a clear in the same cycle
      flag_q <= upd | (flag_q & ~clr_i[SBA_ST_FLAG]); // RL5
      dir_q  <= upd ? rnw_i : (dir_q & ~clr_i[SBA_ST_DIR]); // RL6
      flk_q  <= upd | (flk_q & ~clr_i[SBA_ST_FLK]); // RL7
      alk_q  <= (tmo_i & addr_take_i) | (alk_q & ~clr_i[SBA_ST_ALK]); // RL8
    end
  end

  assign slot_o = {alk_q, flk_q, dir_q, flag_q};
endmodule

// file: testbench/sba_arbiter_checker.sv
// Port assertions for the system bus arbiter
module sba_arbiter_checker
  import sba_pkg::*;
#(
  parameter int TIMEOUT_CYC = SBA_TIMEOUT_CYC
)
(
  // Clock, reset and masters
  input wire logic                  ref_clk_i,
  input wire logic                  rstn_i,
  input wire sba_mreq_s [3:0]       mreq_i,
  input wire logic      [3:0]       gnt_o,
  input wire logic      [3:0]       tmo_o,
  // Register port
  input wire logic [SBA_DCR_AW-1:0] dcr_addr_i,
  input wire logic                  dcr_read_i,
  input wire logic                  dcr_write_i,
  input wire logic [31:0]           dcr_wdata_i,
  input wire logic [31:0]           dcr_rdata_o,
  input wire logic                  dcr_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rq;
  int         cnt_q;
  assign rq = {mreq_i[3].req, mreq_i[2].req, mreq_i[1].req, mreq_i[0].req};
  // Granted cycles so far in the current tenure
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= 0;
    else cnt_q <= (|gnt_o) ? cnt_q + 1 : 0;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  grant_onehot_a: assert property ($onehot0(gnt_o))
    else $error("grant not one-hot");
  idle_grant_a: assert property (rq != 4'h0 && gnt_o == 4'h0 &&
    $past(gnt_o) == 4'h0 |=> gnt_o != 4'h0) else $error("no grant");
  grant_release_a: assert property (|(gnt_o & ~rq) |=> gnt_o == 4'h0)
    else $error("grant held without request");
  tmo_drop_a: assert property (|tmo_o |=> gnt_o == 4'h0)
    else $error("grant kept after timeout");
  tmo_owner_a: assert property (|tmo_o |-> tmo_o == gnt_o)
    else $error("timeout not on owner");
  tmo_len_a: assert property (|tmo_o |-> cnt_q == TIMEOUT_CYC - 1)
    else $error("timeout at wrong cycle");
  reg_ack_a: assert property (dcr_read_i || dcr_write_i |=> dcr_ack_o)
    else $error("register access not acknowledged");
  ctrl_resv_a: assert property (dcr_read_i && dcr_addr_i == SBA_OFF_CTRL
    |=> dcr_rdata_o[31:5] == 27'h0) else $error("reserved bits set");
endmodule
bind sba_arbiter sba_arbiter_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mreq_i(mreq_i), .gnt_o(gnt_o),
  .tmo_o(tmo_o), .dcr_addr_i(dcr_addr_i), .dcr_read_i(dcr_read_i),
  .dcr_write_i(dcr_write_i), .dcr_wdata_i(dcr_wdata_i),
  .dcr_rdata_o(dcr_rdata_o), .dcr_ack_o(dcr_ack_o));

// file: testbench/sba_master_model.sv
// Bus master model for masters 0, 1, 2 and 5
module sba_master_model
  import sba_pkg::*;
(
  // Commands from the bench
  input  wire logic [3:0]  want_i,
  input  wire logic        rnw_i,
  input  wire logic [31:0] addr_i,
  // Requests to the arbiter
  output sba_mreq_s [3:0]  mreq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle masters show inverted qualifiers so stale values never look live
  always_comb begin
    for (int m = 0; m < SBA_MASTERS; m++) begin
      mreq_o[m].req  = want_i[m];
      mreq_o[m].rnw  = want_i[m] ? rnw_i : ~rnw_i;
      mreq_o[m].addr = want_i[m] ? addr_i : ~addr_i;
    end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the system bus arbiter
module testbench
  import sba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            ref_clk_i = 1'b0;
  logic            rstn_i = 1'b0;
  logic [3:0]      want = 4'h0;
  logic            rnw = 1'b0;
  logic [31:0]     addr = 32'h0;
  sba_mreq_s [3:0] mreq;
  logic [3:0]      gnt;
  logic [3:0]      tmo;
  logic [9:0]      dcr_addr = 10'h000;
  logic            rd = 1'b0;
  logic            wr = 1'b0;
  logic            ack;
  logic [31:0]     wdata = 32'h0;
  logic [31:0]     rdata;
  logic [31:0]     r;
  int              fail_count = 0;
  int              n_checks = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  sba_master_model i_model (.want_i(want), .rnw_i(rnw), .addr_i(addr),
    .mreq_o(mreq));
  sba_arbiter #(.TIMEOUT_CYC(4)) i_dut (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .mreq_i(mreq), .gnt_o(gnt), .tmo_o(tmo),
    .dcr_addr_i(dcr_addr), .dcr_read_i(rd), .dcr_write_i(wr),
    .dcr_wdata_i(wdata), .dcr_rdata_o(rdata), .dcr_ack_o(ack));
  task automatic summarize;
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic dcr(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    dcr_addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
    // Ack and read data stand for the one cycle after the strobe edge
    #1;
    chk({31'h0, ack}, 32'h1);
    r = rdata;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    dcr(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  // Request, check the winner, optionally hold until timeout, then release
  task automatic tenure(input logic [3:0] w, input logic [3:0] exp,
                        input logic hold, input logic rw,
                        input logic [31:0] a);
    int i;
    @(posedge ref_clk_i);
    want <= w;
    rnw <= rw;
    addr <= a;
    for (i = 0; i < 40 && gnt == 4'h0; i++) @(posedge ref_clk_i) #1;
    chk({28'h0, gnt}, {28'h0, exp});
    for (i = 0; hold && i < 40 && tmo == 4'h0; i++) @(posedge ref_clk_i) #1;
    if (hold) chk({28'h0, tmo}, {28'h0, exp});
    if (i == 40) summarize;
    @(posedge ref_clk_i);
    want <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rdchk(SBA_OFF_CTRL, 32'h0);
    rdchk(SBA_OFF_STATUS, 32'h0);
    rdchk(SBA_OFF_ADDR, 32'h0);
    rdchk(10'h085, 32'h0);
    dcr(1'b1, SBA_OFF_CTRL, 32'hFFFFFFFF);
    rdchk(SBA_OFF_CTRL, 32'h1F);
    for (int c = 0; c < 4; c++) begin
      dcr(1'b1, SBA_OFF_CTRL, 32'(c) << 1);
      tenure(4'hF, 4'h1 << c, 1'b0, 1'b0, 32'h0);
    end
    dcr(1'b1, SBA_OFF_CTRL, 32'h1);
    tenure(4'h1, 4'h1, 1'b0, 1'b0, 32'h0);
    tenure(4'hF, 4'h2, 1'b0, 1'b0, 32'h0);
    dcr(1'b1, SBA_OFF_CTRL, 32'h0);
    tenure(4'h2, 4'h2, 1'b1, 1'b1, 32'hA5A50010);
    rdchk(SBA_OFF_STATUS, 32'h0F0);
    rdchk(SBA_OFF_ADDR, 32'hA5A50010);
    tenure(4'h1, 4'h1, 1'b1, 1'b0, 32'h5A5A0020);
    rdchk(SBA_OFF_STATUS, 32'h0F5);
    tenure(4'h1, 4'h1, 1'b1, 1'b1, 32'h5A5A0030);
    rdchk(SBA_OFF_STATUS, 32'h0F5);
    rdchk(SBA_OFF_ADDR, 32'hA5A50010);
    dcr(1'b1, SBA_OFF_STATUS, 32'hFFF);
    rdchk(SBA_OFF_STATUS, 32'h0);
    tenure(4'h4, 4'h4, 1'b1, 1'b1, 32'h3C3C0040);
    rdchk(SBA_OFF_STATUS, 32'hF00);
    rdchk(SBA_OFF_ADDR, 32'h3C3C0040);
    summarize;
  end
endmodule
